// ### byte_bank.sv
/*
 * one bank of byte-wide ram with clocked write and combinational read.
 * assumes the caller registers the read data where timing needs it.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_bank #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);

   logic [7:0] mem [2**ADDR_W];

   // no reset on contents: ram powers up undefined, as on silicon
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];

endmodule
`default_nettype wire

// ### data_ram_map.svh
/*
 * offsets, key values, field positions and reset values for the on-chip
 * data ram decoder and its configuration registers.
 * assumes it is included by bare name from the package and the design.
 */
// Functional notes
// - 512 bytes: scratchpad bank plus auxiliary bank
// - scratch 00-7f by direct and indirect
// - scratch 80-ff indirect only, direct hits registers
// - aux 00-ff via external moves, Ri or pointer pair
// - external moves above ff use external bus
// - aux ram disabled after reset
// - config bit 4 enables aux ram
// - enabled: Ri external moves always reach aux
// - aux access leaves ports and strobes untouched
`ifndef DATA_RAM_MAP_SVH
`define DATA_RAM_MAP_SVH

`define CHIP_CONFIG_ADDR    8'hbf
`define CONFIG_UNLOCK_ADDR  8'hf6
`define UNLOCK_KEY_FIRST    8'h87
`define UNLOCK_KEY_SECOND   8'h59
`define UNLOCK_KEY_RELOCK   8'h00
`define AUX_ENABLE_BIT      4
`define CHIP_CONFIG_RESET   8'h00
`define CHIP_CONFIG_WMASK   8'h9f
`define DIRECT_RAM_LIMIT    8'h80
`define AUX_RAM_TOP         16'h00ff
`define PORT_TWO_RESET      8'hff
`define EXT_STROBE_CYCLES   2

`endif

// ### data_ram_pkg.sv
/*
 * types shared by the data ram decoder: access kinds, request and answer
 * carriers, routing targets and states.
 * assumes data_ram_map.svh is reachable by bare name.
 */
`include "data_ram_map.svh"
package data_ram_pkg;

   typedef enum logic [1:0] {
      ACC_DIRECT,
      ACC_INDIRECT,
      ACC_MOVX_RI,
      ACC_MOVX_DATA_POINTER_PAIR
   } access_kind_t;

   typedef struct packed {
      logic         valid;
      access_kind_t kind;
      logic         write;
      logic [15:0]  addr;
      logic [7:0]   wdata;
   } core_req_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] rdata;
   } core_resp_t;

   typedef enum logic [1:0] {
      TGT_SCRATCH,
      TGT_SFR,
      TGT_AUX,
      TGT_EXT
   } target_t;

   typedef enum {
      EXT_IDLE,
      EXT_ADDR,
      EXT_STROBE
   } ext_state_t;

   typedef enum {
      LOCK_CLOSED,
      LOCK_FIRST_OK,
      LOCK_OPEN
   } lock_state_t;

endpackage

// ### data_ram_sva.sv
/* assertions on the data ram decoder ports.
   assumes the default two-cycle strobe and the package compiled first. */
`timescale 1ns/1ps
`default_nettype none
module data_ram_sva
   import data_ram_pkg::*;
#(
   parameter int STROBE_CYCLES = 2
) (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire core_req_t  core_req,
   input wire core_resp_t core_resp,
   input wire logic       busy,
   input wire logic       aux_enabled,
   input wire logic [7:0] port_zero_addr_data_out,
   input wire logic       port_zero_addr_data_oe,
   input wire logic [7:0] port_two_high_addr,
   input wire logic       ext_ale,
   input wire logic       ext_wr_n,
   input wire logic       ext_rd_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire take = core_req.valid && !busy;
   wire movx = core_req.kind inside {ACC_MOVX_RI, ACC_MOVX_DATA_POINTER_PAIR};
   wire aux_hit = aux_enabled && (core_req.kind == ACC_MOVX_RI || core_req.addr <= 16'h00ff);
   wire quiet = !ext_ale && ext_wr_n && ext_rd_n && !port_zero_addr_data_oe;
   wire cfg_wr = take && core_req.write && core_req.kind == ACC_DIRECT &&
                 core_req.addr[7:0] == 8'hbf;
   logic [15:0] addr_q;
   logic        cfg_wr_q;
   // helper copies of last cycle's address and config write, used in place of $past
   always_ff @(posedge clk_sys) begin
      addr_q <= core_req.addr;
      cfg_wr_q <= cfg_wr;
   end
   sequence ext_cycle_s;
      busy[*3] ##1 (!busy && core_resp.ack);
   endsequence
   sequence addr_phase_s;
      ext_ale && port_zero_addr_data_oe && port_zero_addr_data_out == addr_q[7:0];
   endsequence
   a_internal_ack: assert property (take && !movx |=> core_resp.ack && !busy)
      else $error("internal access not answered next cycle");
   a_aux_quiet: assert property (take && movx && aux_hit |=>
      core_resp.ack && quiet && $stable(port_two_high_addr))
      else $error("aux access moved the bus");
   a_ext_cycle: assert property (take && movx && !aux_hit |=> ext_cycle_s)
      else $error("external cycle length wrong");
   a_ri_addr: assert property (take && core_req.kind == ACC_MOVX_RI && !aux_enabled |=>
      addr_phase_s and $stable(port_two_high_addr))
      else $error("pointer byte not on low port");
   a_data_pointer_pair_addr: assert property (take && core_req.kind == ACC_MOVX_DATA_POINTER_PAIR &&
      core_req.addr > 16'h00ff |=> addr_phase_s and port_two_high_addr == addr_q[15:8])
      else $error("pointer pair not on ports");
   a_aux_off_reset: assert property ($rose(rst_n) |-> !aux_enabled)
      else $error("aux enabled out of reset");
   a_cfg_cause: assert property ($changed(aux_enabled) |-> cfg_wr_q)
      else $error("aux enable changed without config write");
   a_ale_pulse: assert property (ext_ale |=> !ext_ale && busy)
      else $error("address strobe longer than one cycle");
   a_strobe_busy: assert property (!ext_wr_n || !ext_rd_n |->
      busy && (ext_wr_n || ext_rd_n))
      else $error("strobe outside a bus cycle");
endmodule
bind onchip_data_ram_aux_access data_ram_sva #(.STROBE_CYCLES(STROBE_CYCLES)) data_ram_sva_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .core_req(core_req), .core_resp(core_resp),
   .busy(busy), .aux_enabled(aux_enabled), .port_zero_addr_data_out(port_zero_addr_data_out),
   .port_zero_addr_data_oe(port_zero_addr_data_oe), .port_two_high_addr(port_two_high_addr),
   .ext_ale(ext_ale), .ext_wr_n(ext_wr_n), .ext_rd_n(ext_rd_n));
`default_nettype wire

// ### ext_data_mem.sv
/* external data memory on the multiplexed bus.
   assumes address latched on the address strobe cycle. */
`timescale 1ns/1ps
`default_nettype none
module ext_data_mem (
   input  wire logic [7:0] port_zero_addr_data_out,
   input  wire logic [7:0] port_two_high_addr,
   input  wire logic       clk_sys,
   input  wire logic       ext_ale,
   input  wire logic       ext_wr_n,
   input  wire logic       ext_rd_n,
   output logic      [7:0] port_zero_addr_data_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr = 16'h0000;
   logic [7:0]  last = 8'h00;
   always @(posedge clk_sys) begin
      if (ext_ale) addr <= {port_two_high_addr, port_zero_addr_data_out};
      if (!ext_wr_n) mem[addr] <= port_zero_addr_data_out;
      if (!ext_rd_n) last <= mem[addr];
   end
   // no pull-ups on the low port: a released bus must not look like data
   assign port_zero_addr_data_in = !ext_rd_n ? mem[addr] : ~last;
endmodule
`default_nettype wire

// ### onchip_data_ram_aux_access.sv
/*
 * decodes core data accesses onto the scratchpad bank, the auxiliary bank,
 * the two configuration registers and the external data bus.
 * assumes the core holds a request only while busy is low and resolves
 * Ri of the selected bank into the request address itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_map.svh"
module onchip_data_ram_aux_access
   import data_ram_pkg::*;
#(
   parameter int STROBE_CYCLES = `EXT_STROBE_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire core_req_t  core_req,
   output core_resp_t      core_resp,
   output logic            busy,
   output logic            aux_enabled,
   output logic [7:0]      port_zero_addr_data_out,
   output logic            port_zero_addr_data_oe,
   input  wire logic [7:0] port_zero_addr_data_in,
   output logic [7:0]      port_two_high_addr,
   output logic            ext_ale,
   output logic            ext_wr_n,
   output logic            ext_rd_n
);

   ext_state_t  ext_state;
   lock_state_t lock_state;
   logic [7:0]  chip_config;
   logic [7:0]  strobe_cnt;
   logic        ext_write;
   logic [7:0]  ext_wdata;
   logic [7:0]  scratch_rdata;
   logic [7:0]  aux_rdata;
   target_t     target;
   logic        take;
   logic        unlock_wr;
   logic        cfg_wr;
   logic        scratch_we;
   logic        aux_we;

   function automatic target_t decode(input access_kind_t kind,
                                      input logic [15:0]  addr,
                                      input logic         aux_on);
      case (kind)
         ACC_DIRECT:    decode = (addr[7:0] < `DIRECT_RAM_LIMIT) ?
                                 TGT_SCRATCH : TGT_SFR;
         ACC_INDIRECT:  decode = TGT_SCRATCH;
         ACC_MOVX_RI:   decode = aux_on ? TGT_AUX : TGT_EXT;
         ACC_MOVX_DATA_POINTER_PAIR: decode = (aux_on && addr <= `AUX_RAM_TOP) ?
                                 TGT_AUX : TGT_EXT;
         default:       decode = TGT_EXT;
      endcase
   endfunction

   function automatic logic [7:0] sfr_read(input logic [7:0]  addr,
                                           input logic [7:0]  cfg,
                                           input lock_state_t lock);
      if (addr == `CHIP_CONFIG_ADDR) begin
         sfr_read = cfg;
      end else if (addr == `CONFIG_UNLOCK_ADDR) begin
         sfr_read = {7'h00, lock == LOCK_OPEN};
      end else begin
         sfr_read = 8'h00;
      end
   endfunction

   // one decode for every register write strobe, so lock and config agree
   function automatic logic sfr_write(input logic       taken,
                                      input core_req_t  req,
                                      input target_t    tgt,
                                      input logic [7:0] reg_addr);
      sfr_write = taken && req.write && tgt == TGT_SFR && req.addr[7:0] == reg_addr;
   endfunction

   assign take   = core_req.valid && !busy;
   assign target = decode(core_req.kind, core_req.addr, aux_enabled);

   // write strobes decoded once for the two banks and the two registers
   assign unlock_wr  = sfr_write(take, core_req, target, `CONFIG_UNLOCK_ADDR);
   assign cfg_wr     = sfr_write(take, core_req, target, `CHIP_CONFIG_ADDR);
   assign scratch_we = take && core_req.write && target == TGT_SCRATCH;
   assign aux_we     = take && core_req.write && target == TGT_AUX;

   // two banks of 256, each on its own path
   byte_bank #(.ADDR_W(8)) scratch_bank (
      .clk_sys (clk_sys),
      .we      (scratch_we),
      .addr    (core_req.addr[7:0]),
      .wdata   (core_req.wdata),
      .rdata   (scratch_rdata)
   );

   byte_bank #(.ADDR_W(8)) aux_bank (
      .clk_sys (clk_sys),
      .we      (aux_we),
      .addr    (core_req.addr[7:0]),
      .wdata   (core_req.wdata),
      .rdata   (aux_rdata)
   );

   // unlock sequence; a stray value mid-sequence drops back to closed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lock_state <= LOCK_CLOSED;
      end else if (unlock_wr) begin
         case (lock_state)
            LOCK_CLOSED:   lock_state <= (core_req.wdata == `UNLOCK_KEY_FIRST) ?
                                         LOCK_FIRST_OK : LOCK_CLOSED;
            LOCK_FIRST_OK: lock_state <= (core_req.wdata == `UNLOCK_KEY_SECOND) ?
                                         LOCK_OPEN : LOCK_CLOSED;
            LOCK_OPEN:     lock_state <= (core_req.wdata == `UNLOCK_KEY_RELOCK) ?
                                         LOCK_CLOSED : LOCK_OPEN;
            default:       lock_state <= LOCK_CLOSED;
         endcase
      end
   end

   // config only changes while unlocked; guards against runaway code
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chip_config <= `CHIP_CONFIG_RESET;
      end else if (cfg_wr && lock_state == LOCK_OPEN) begin
         chip_config <= core_req.wdata & `CHIP_CONFIG_WMASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aux_enabled <= 1'b0;
      end else if (cfg_wr && lock_state == LOCK_OPEN) begin
         aux_enabled <= core_req.wdata[`AUX_ENABLE_BIT];
      end
   end

   // answers: internal targets in one cycle, external at end of strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         core_resp <= '0;
      end else begin
         core_resp.ack <= 1'b0;
         if (take && target != TGT_EXT) begin
            core_resp.ack <= 1'b1;
            case (target)
               TGT_SCRATCH: core_resp.rdata <= scratch_rdata;
               TGT_AUX:     core_resp.rdata <= aux_rdata;
               TGT_SFR:     core_resp.rdata <= sfr_read(core_req.addr[7:0],
                                                        chip_config, lock_state);
               default:     core_resp.rdata <= 8'h00;
            endcase
         end else if (ext_state == EXT_STROBE && strobe_cnt == 8'h01) begin
            // busy falls with this ack, so the next take waits one edge
            core_resp.ack   <= 1'b1;
            core_resp.rdata <= ext_write ? 8'h00 : port_zero_addr_data_in;
         end
      end
   end

   // external bus cycle; aux and scratch never reach this machine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_state               <= EXT_IDLE;
         busy                    <= 1'b0;
         strobe_cnt              <= 8'h00;
         ext_write               <= 1'b0;
         ext_wdata               <= 8'h00;
         port_zero_addr_data_out <= 8'h00;
         port_zero_addr_data_oe  <= 1'b0;
         port_two_high_addr      <= `PORT_TWO_RESET;
         ext_ale                 <= 1'b0;
         ext_wr_n                <= 1'b1;
         ext_rd_n                <= 1'b1;
      end else begin
         case (ext_state)
            EXT_IDLE: begin
               if (take && target == TGT_EXT) begin
                  ext_state               <= EXT_ADDR;
                  busy                    <= 1'b1;
                  ext_write               <= core_req.write;
                  ext_wdata               <= core_req.wdata;
                  port_zero_addr_data_out <= core_req.addr[7:0];
                  port_zero_addr_data_oe  <= 1'b1;
                  ext_ale                 <= 1'b1;
                  // Ri moves leave the high byte at the port latch
                  if (core_req.kind == ACC_MOVX_DATA_POINTER_PAIR) begin
                     port_two_high_addr <= core_req.addr[15:8];
                  end
               end
            end
            EXT_ADDR: begin
               // low port turns round: write data driven, released for a read
               ext_state               <= EXT_STROBE;
               ext_ale                 <= 1'b0;
               strobe_cnt              <= STROBE_CYCLES[7:0];
               port_zero_addr_data_out <= ext_write ? ext_wdata : 8'h00;
               port_zero_addr_data_oe  <= ext_write;
               ext_wr_n                <= !ext_write;
               ext_rd_n                <= ext_write;
            end
            EXT_STROBE: begin
               // answer block samples read data on the last strobe edge
               strobe_cnt <= strobe_cnt - 8'h01;
               if (strobe_cnt == 8'h01) begin
                  ext_state              <= EXT_IDLE;
                  busy                   <= 1'b0;
                  ext_wr_n               <= 1'b1;
                  ext_rd_n               <= 1'b1;
                  port_zero_addr_data_oe <= 1'b0;
               end
            end
            default: begin
               ext_state <= EXT_IDLE;
               busy      <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### onchip_data_ram_aux_access_bench.sv
/* self-checking bench for the data ram decoder with an external memory model.
   assumes the default strobe length. */
`timescale 1ns/1ps
`default_nettype none
`include "data_ram_map.svh"
module onchip_data_ram_aux_access_bench
   import data_ram_pkg::*;
();
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   core_req_t  core_req = '0;
   core_resp_t core_resp;
   logic       busy, aux_enabled, p0_oe, ale, wr_n, rd_n;
   logic [7:0] p0_out, p0_in, p2;
   int         mismatches = 0;
   int         compares = 0;
   onchip_data_ram_aux_access onchip_data_ram_aux_access_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .core_req(core_req), .core_resp(core_resp), .busy(busy), .aux_enabled(aux_enabled),
      .port_zero_addr_data_out(p0_out), .port_zero_addr_data_oe(p0_oe),
      .port_zero_addr_data_in(p0_in), .port_two_high_addr(p2), .ext_ale(ale),
      .ext_wr_n(wr_n), .ext_rd_n(rd_n));
   ext_data_mem ext_data_mem_i (.port_zero_addr_data_out(p0_out), .port_two_high_addr(p2),
      .clk_sys(clk_sys), .ext_ale(ale), .ext_wr_n(wr_n), .ext_rd_n(rd_n),
      .port_zero_addr_data_in(p0_in));
   task automatic conclude();
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one request; an external cycle drops valid after its take edge, an
   // internal answer is already back and the next call overwrites at once
   task automatic acc(input access_kind_t k, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      int n;
      core_req = '{1'b1, k, w, a, d};
      @(posedge clk_sys);
      #1 n = 0;
      if (core_resp.ack !== 1'b1) begin
         core_req.valid = 1'b0;
      end
      while (core_resp.ack !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (core_resp.ack !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED ack expected 1 seen %b", core_resp.ack);
         conclude();
      end
   endtask
   task automatic rd(input access_kind_t k, input logic [15:0] a, input logic [7:0] e,
                     input string nm);
      acc(k, 1'b0, a, 8'h00);
      chk(nm, e, core_resp.rdata);
   endtask
   task automatic setcfg(input logic [7:0] v);
      acc(ACC_DIRECT, 1'b1, {8'h00, `CONFIG_UNLOCK_ADDR}, `UNLOCK_KEY_FIRST);
      acc(ACC_DIRECT, 1'b1, {8'h00, `CONFIG_UNLOCK_ADDR}, `UNLOCK_KEY_SECOND);
      rd(ACC_DIRECT, {8'h00, `CONFIG_UNLOCK_ADDR}, 8'h01, "unlock open");
      acc(ACC_DIRECT, 1'b1, {8'h00, `CHIP_CONFIG_ADDR}, v);
      acc(ACC_DIRECT, 1'b1, {8'h00, `CONFIG_UNLOCK_ADDR}, `UNLOCK_KEY_RELOCK);
      rd(ACC_DIRECT, {8'h00, `CONFIG_UNLOCK_ADDR}, 8'h00, "relocked");
   endtask
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      rd(ACC_DIRECT, 16'h00bf, 8'h00, "cfg after reset");
      acc(ACC_MOVX_RI, 1'b1, 16'h0012, 8'h5a);
      chk("ext ff12", 8'h5a, ext_data_mem_i.mem[16'hff12]);
      acc(ACC_DIRECT, 1'b1, 16'h00bf, 8'h10);
      rd(ACC_DIRECT, 16'h00bf, 8'h00, "cfg locked");
      acc(ACC_DIRECT, 1'b1, {8'h00, `CONFIG_UNLOCK_ADDR}, `UNLOCK_KEY_FIRST);
      acc(ACC_DIRECT, 1'b1, {8'h00, `CONFIG_UNLOCK_ADDR}, 8'h12);
      acc(ACC_DIRECT, 1'b1, 16'h00bf, 8'h10);
      rd(ACC_DIRECT, 16'h00bf, 8'h00, "cfg wrong key");
      setcfg(8'h10);
      rd(ACC_DIRECT, 16'h00bf, 8'h10, "cfg set");
      chk("aux on", 8'h01, {7'h00, aux_enabled});
      acc(ACC_MOVX_RI, 1'b1, 16'h0012, 8'ha5);
      rd(ACC_MOVX_RI, 16'h0012, 8'ha5, "aux ri");
      rd(ACC_MOVX_DATA_POINTER_PAIR, 16'h0012, 8'ha5, "aux data_pointer_pair");
      chk("ext kept", 8'h5a, ext_data_mem_i.mem[16'hff12]);
      acc(ACC_MOVX_DATA_POINTER_PAIR, 1'b1, 16'h1234, 8'h77);
      chk("ext 1234", 8'h77, ext_data_mem_i.mem[16'h1234]);
      rd(ACC_MOVX_DATA_POINTER_PAIR, 16'h1234, 8'h77, "ext data_pointer_pair");
      acc(ACC_DIRECT, 1'b1, 16'h0005, 8'h11);
      rd(ACC_INDIRECT, 16'h0005, 8'h11, "scratch low");
      acc(ACC_INDIRECT, 1'b1, 16'h0090, 8'h22);
      acc(ACC_MOVX_RI, 1'b1, 16'h0090, 8'h33);
      rd(ACC_INDIRECT, 16'h0090, 8'h22, "scratch high");
      rd(ACC_DIRECT, 16'h0090, 8'h00, "direct high");
      setcfg(8'h00);
      acc(ACC_MOVX_RI, 1'b1, 16'h0044, 8'h66);
      chk("ext ri off", 8'h66, ext_data_mem_i.mem[16'h1244]);
      setcfg(8'h10);
      core_req.valid = 1'b0;
      rst_n = 1'b0;
      @(posedge clk_sys);
      #1 rst_n = 1'b1;
      chk("aux after reset", 8'h00, {7'h00, aux_enabled});
      rd(ACC_DIRECT, 16'h00bf, 8'h00, "cfg after second reset");
      rd(ACC_MOVX_RI, 16'h0012, 8'h5a, "ext after reset");
      conclude();
   end
endmodule
`default_nettype wire
